// ===== hw/mpc_pkg.sv
// Package for the port and comparator I/O block: offsets, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus and one 20 MHz clock.
package mpc_pkg;
  // ********************************************************************
  // Register byte offsets
  // ********************************************************************
  localparam logic [7:0] PORT_CONFIG_OFF = 8'h00;
  localparam logic [7:0] PORT0_DATA_OFF = 8'h04;
  localparam logic [7:0] PORT0_MODE_OFF = 8'h08;
  localparam logic [7:0] PORT2_DATA_OFF = 8'h0C;
  localparam logic [7:0] PORT2_MODE_OFF = 8'h10;
  localparam logic [7:0] PORT2_PULLUP_OFF = 8'h14;
  localparam logic [7:0] PORT3_DATA_OFF = 8'h18;
  localparam logic [7:0] PORT3_MODE_OFF = 8'h1C;
  localparam logic [7:0] IRQ_EDGE_OFF = 8'h20;
  localparam logic [7:0] STOP_SEL_OFF = 8'h24;
  localparam logic [7:0] EVENT_OFF = 8'h28;
  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CFG_CMPA_OUT_BIT = 0;
  localparam int P0M_LOW_DIR_BIT = 0;
  localparam int P0M_HIGH_DIR_BIT = 1;
  localparam int P3M_ANALOG_BIT = 1;
  localparam int P3M_SLEW_BIT = 0;
  localparam int EDGE_SEL_LO_BIT = 6;
  localparam int EDGE_SEL_HI_BIT = 7;
  localparam int EV_INT_TWO_BIT = 0;
  localparam int EV_INT_ZERO_BIT = 1;
  localparam int EV_INT_ONE_BIT = 2;
  // ********************************************************************
  // Reset values (direction bits: 1 = input) and response codes
  // ********************************************************************
  localparam logic [7:0] PORT_CONFIG_RST = 8'h00;
  localparam logic [1:0] PORT0_MODE_RST = 2'h3;
  localparam logic [7:0] PORT2_MODE_RST = 8'hFF;
  localparam logic [7:0] PORT2_PULLUP_RST = 8'h00;
  localparam logic [1:0] PORT3_MODE_RST = 2'h0;
  localparam logic [7:0] IRQ_EDGE_RST = 8'h00;
  localparam logic [2:0] STOP_SEL_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/mpc_port_io.sv
// Port 0, port 2 and port 3 logic with comparator routing, AXI4-Lite regs.
// Assumes synchronous pins, comparator results from an analogue front end.
`timescale 1ns/1ns
module mpc_port_io (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wdt_rst_i,
  input wire logic stop_mode_i,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [6:0] port0_in_i,
  output logic [6:0] port0_out_o,
  output logic [6:0] port0_oe_o,
  input wire logic [7:0] port2_lines_in_i,
  output logic [7:0] port2_lines_out_o,
  output logic [7:0] port2_lines_oe_o,
  output logic [7:0] port2_pullup_o,
  output logic [7:0] adc_chan_en_o,
  input wire logic port3_in_a_i,
  input wire logic port3_in_b_i,
  input wire logic port3_in_ref_i,
  input wire logic comparator_a_i,
  input wire logic comparator_b_i,
  input wire logic [7:0] stop_src_i,
  input wire logic port0_hs_i,
  input wire logic timer1_out_i,
  input wire logic port2_hs_i,
  input wire logic [1:0] hs_sel_i,
  output logic port3_out_a_o,
  output logic port3_out_b_o,
  output logic port3_out_c_o,
  output logic port3_slew_o,
  output logic comp_en_o,
  output logic timer1_in_o,
  output logic ext_int_zero_o,
  output logic ext_int_one_o,
  output logic ext_int_two_o
);
  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [7:0] port_config_q;
  logic [6:0] port0_data_q;
  logic [1:0] port0_mode_q;
  logic [3:0] port0_hold_q;
  logic [7:0] port2_data_q;
  logic [7:0] port2_mode_q;
  logic [7:0] port2_pullup_enable_q;
  logic [2:0] port3_data_q;
  logic [1:0] port3_mode_reg_q;
  logic [7:0] irq_edge_q;
  logic [2:0] stop_recovery_select_q;
  logic [2:0] event_q;
  logic [2:0] p3_in_q;
  logic aw_got_q, w_got_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic analog_mode, wr_go, rd_go, ev_clr;
  logic [2:0] p3_in_d, rise, fall, ev_set;
  logic [6:0] port0_dir_in;
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  assign analog_mode = port3_mode_reg_q[mpc_pkg::P3M_ANALOG_BIT];
  // Direction bit high means input
  assign port0_dir_in = {{3{port0_mode_q[mpc_pkg::P0M_HIGH_DIR_BIT]}},
                         {4{port0_mode_q[mpc_pkg::P0M_LOW_DIR_BIT]}}};
  assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // ********************************************************************
  // Port 3 inputs; comparator path in analog mode
  // ********************************************************************
  always_comb begin
    if (analog_mode) begin
      p3_in_d[0] = comparator_a_i;
      p3_in_d[1] = comparator_b_i;
      p3_in_d[2] = stop_src_i[stop_recovery_select_q];
    end else begin
      p3_in_d = {port3_in_ref_i, port3_in_b_i, port3_in_a_i};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p3_in_q <= 3'h0;
    end else begin
      p3_in_q <= p3_in_d;
    end
  end

  assign rise = p3_in_d & ~p3_in_q;
  assign fall = ~p3_in_d & p3_in_q;
  // Edge code: bit 7 steers input a, bit 6 steers input b
  assign ev_set[mpc_pkg::EV_INT_TWO_BIT] =
    irq_edge_q[mpc_pkg::EDGE_SEL_HI_BIT] ?
      (rise[0] | (irq_edge_q[mpc_pkg::EDGE_SEL_LO_BIT] & fall[0])) :
      fall[0];
  assign ev_set[mpc_pkg::EV_INT_ZERO_BIT] =
    irq_edge_q[mpc_pkg::EDGE_SEL_LO_BIT] ?
      (rise[1] | (irq_edge_q[mpc_pkg::EDGE_SEL_HI_BIT] & fall[1])) :
      fall[1];
  assign ev_set[mpc_pkg::EV_INT_ONE_BIT] = fall[2];

  // ********************************************************************
  // Interrupt request pulses and sticky event flags
  // ********************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_int_two_o <= 1'b0;
      ext_int_zero_o <= 1'b0;
      ext_int_one_o <= 1'b0;
      timer1_in_o <= 1'b0;
    end else begin
      ext_int_two_o <= ev_set[mpc_pkg::EV_INT_TWO_BIT];
      ext_int_zero_o <= ev_set[mpc_pkg::EV_INT_ZERO_BIT];
      ext_int_one_o <= ev_set[mpc_pkg::EV_INT_ONE_BIT];
      timer1_in_o <= p3_in_d[0];
    end
  end

  assign ev_clr = wr_go && aw_addr_q == mpc_pkg::EVENT_OFF && w_strb_q[0];
  // Set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_q <= 3'h0;
    end else begin
      event_q <= (ev_clr ? (event_q & ~w_data_q[2:0]) : event_q) | ev_set;
    end
  end

  // ********************************************************************
  // Pin drivers
  // ********************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port0_out_o <= 7'h00;
      port0_oe_o <= 7'h00;
      port2_lines_out_o <= 8'h00;
      port2_lines_oe_o <= 8'h00;
      port2_pullup_o <= 8'h00;
      adc_chan_en_o <= 8'h00;
      port3_out_a_o <= 1'b0;
      port3_out_b_o <= 1'b0;
      port3_out_c_o <= 1'b0;
      port3_slew_o <= 1'b0;
      comp_en_o <= 1'b0;
    end else begin
      port0_out_o <= port0_data_q;
      port0_oe_o <= ~port0_dir_in;
      port2_lines_out_o <= port2_data_q;
      port2_lines_oe_o <= ~port2_mode_q;
      port2_pullup_o <= port2_pullup_enable_q & port2_mode_q;
      adc_chan_en_o <= port2_mode_q;
      port3_out_a_o <= port_config_q[mpc_pkg::CFG_CMPA_OUT_BIT] ?
                       comparator_a_i : port3_data_q[0];
      port3_out_b_o <= hs_sel_i[0] ? port0_hs_i : port3_data_q[1];
      port3_out_c_o <= hs_sel_i[1] ? port2_hs_i :
                       (timer1_out_i | port3_data_q[2]);
      port3_slew_o <= port3_mode_reg_q[mpc_pkg::P3M_SLEW_BIT];
      comp_en_o <= analog_mode;
    end
  end

  // ********************************************************************
  // Hold latches on upper port 0 lines
  // ********************************************************************
  // Level is whatever the pin last showed; cleared to zero by reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port0_hold_q <= 4'h0;
    end else begin
      port0_hold_q <= port0_in_i[6:3];
    end
  end

  // ********************************************************************
  // Config register: power-on, or watchdog outside stop mode
  // ********************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_config_q <= mpc_pkg::PORT_CONFIG_RST;
    end else if (wdt_rst_i && !stop_mode_i) begin
      port_config_q <= mpc_pkg::PORT_CONFIG_RST;
    end else if (wr_go && aw_addr_q == mpc_pkg::PORT_CONFIG_OFF
                 && w_strb_q[0]) begin
      port_config_q <= w_data_q[7:0];
    end
  end

  // ********************************************************************
  // Other software registers
  // ********************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port0_data_q <= 7'h00;
      port0_mode_q <= mpc_pkg::PORT0_MODE_RST;
      port2_data_q <= 8'h00;
      port2_mode_q <= mpc_pkg::PORT2_MODE_RST;
      port2_pullup_enable_q <= mpc_pkg::PORT2_PULLUP_RST;
      port3_data_q <= 3'h0;
      port3_mode_reg_q <= mpc_pkg::PORT3_MODE_RST;
      irq_edge_q <= mpc_pkg::IRQ_EDGE_RST;
      stop_recovery_select_q <= mpc_pkg::STOP_SEL_RST;
    end else if (wr_go && w_strb_q[0]) begin
      case (aw_addr_q)
        mpc_pkg::PORT0_DATA_OFF: port0_data_q <= w_data_q[6:0];
        mpc_pkg::PORT0_MODE_OFF: port0_mode_q <= w_data_q[1:0];
        mpc_pkg::PORT2_DATA_OFF: port2_data_q <= w_data_q[7:0];
        mpc_pkg::PORT2_MODE_OFF: port2_mode_q <= w_data_q[7:0];
        mpc_pkg::PORT2_PULLUP_OFF: port2_pullup_enable_q <= w_data_q[7:0];
        mpc_pkg::PORT3_DATA_OFF: port3_data_q <= w_data_q[5:3];
        mpc_pkg::PORT3_MODE_OFF: port3_mode_reg_q <= w_data_q[1:0];
        mpc_pkg::IRQ_EDGE_OFF: irq_edge_q <= w_data_q[7:0];
        mpc_pkg::STOP_SEL_OFF: stop_recovery_select_q <= w_data_q[2:0];
        default: ;
      endcase
    end
  end

  // ********************************************************************
  // Read mux
  // ********************************************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      // Config is write-only and reads as zero
      mpc_pkg::PORT_CONFIG_OFF: rd_word = 32'h0000_0000;
      mpc_pkg::PORT0_DATA_OFF: rd_word[6:0] =
        (port0_dir_in & {port0_hold_q, port0_in_i[2:0]}) |
        (~port0_dir_in & port0_data_q);
      mpc_pkg::PORT0_MODE_OFF: rd_word[1:0] = port0_mode_q;
      mpc_pkg::PORT2_DATA_OFF: rd_word[7:0] =
        (port2_mode_q & port2_lines_in_i) |
        (~port2_mode_q & port2_data_q);
      mpc_pkg::PORT2_MODE_OFF: rd_word[7:0] = port2_mode_q;
      mpc_pkg::PORT2_PULLUP_OFF: rd_word[7:0] = port2_pullup_enable_q;
      mpc_pkg::PORT3_DATA_OFF: rd_word[5:0] = {port3_data_q, p3_in_q};
      mpc_pkg::PORT3_MODE_OFF: rd_word[1:0] = port3_mode_reg_q;
      mpc_pkg::IRQ_EDGE_OFF: rd_word[7:0] = irq_edge_q;
      mpc_pkg::STOP_SEL_OFF: rd_word[2:0] = stop_recovery_select_q;
      mpc_pkg::EVENT_OFF: rd_word[2:0] = event_q;
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    wr_ok = 1'b1;
    case (aw_addr_q)
      mpc_pkg::PORT_CONFIG_OFF, mpc_pkg::PORT0_DATA_OFF,
      mpc_pkg::PORT0_MODE_OFF, mpc_pkg::PORT2_DATA_OFF,
      mpc_pkg::PORT2_MODE_OFF, mpc_pkg::PORT2_PULLUP_OFF,
      mpc_pkg::PORT3_DATA_OFF, mpc_pkg::PORT3_MODE_OFF,
      mpc_pkg::IRQ_EDGE_OFF, mpc_pkg::STOP_SEL_OFF,
      mpc_pkg::EVENT_OFF: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // ********************************************************************
  // AXI4-Lite write channel
  // ********************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mpc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? mpc_pkg::RESP_OKAY : mpc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // AXI4-Lite read channel
  // ********************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= mpc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? mpc_pkg::RESP_OKAY : mpc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence s_out_dir(int i);
    !port2_mode_q[i];
  endsequence

  AST_PULLUP_OFF_OUT: assert property (
    s_out_dir(7) |=> !port2_pullup_o[7])
    else $error("Pull-up on while line is output");
  AST_PULLUP_ON_IN: assert property (
    (port2_mode_q[3] && port2_pullup_enable_q[3]) |=> port2_pullup_o[3])
    else $error("Pull-up missing on enabled input");
  AST_P2_DIR: assert property (
    port2_lines_oe_o == ~$past(port2_mode_q))
    else $error("Port 2 enable does not follow mode");
  AST_P0_GROUP: assert property (
    port0_oe_o[3:0] == {4{port0_oe_o[0]}} &&
    port0_oe_o[6:4] == {3{port0_oe_o[4]}})
    else $error("Port 0 group direction split");
  AST_CMPA_ROUTE: assert property (
    port_config_q[0] |=> port3_out_a_o == $past(comparator_a_i))
    else $error("Comparator a not on output a");
  AST_CFG_WDT: assert property (
    (wdt_rst_i && !stop_mode_i) |=> port_config_q == mpc_pkg::PORT_CONFIG_RST)
    else $error("Config survived watchdog reset");
  AST_INT_ONE_FALL: assert property (
    (!analog_mode && $past(!analog_mode) && $fell(port3_in_ref_i))
      |=> ext_int_one_o)
    else $error("Falling ref edge gave no interrupt one");
  AST_EDGE_00: assert property (
    (irq_edge_q[7:6] == 2'h0 && rise[0]) |=> !ext_int_two_o)
    else $error("Rising edge fired with falling-only code");
  AST_EDGE_11: assert property (
    (irq_edge_q[7:6] == 2'h3 && (rise[1] || fall[1])) |=> ext_int_zero_o)
    else $error("Edge missed with both-edges code");
endmodule

// ===== sim/mpc_pin_model.sv
// Board model: resolves port 0 and port 2 pad levels from all drivers.
// Assumes oe high while the block drives; ext_en high while the board drives.
`timescale 1ns/1ns
module mpc_pin_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] p2_out_i,
  input wire logic [7:0] p2_oe_i,
  input wire logic [7:0] p2_pu_i,
  input wire logic [7:0] p2_ext_i,
  input wire logic [7:0] p2_ext_en_i,
  input wire logic [6:0] p0_out_i,
  input wire logic [6:0] p0_oe_i,
  input wire logic [6:0] p0_ext_i,
  output logic [7:0] p2_pin_o,
  output logic [6:0] p0_pin_o
);
  // ****
  // Pad resolution
  // ****
  logic [7:0] last_q = 8'h00;
  // Floating line flips each cycle so no stale level passes
  always_ff @(posedge ref_clk_i) begin
    last_q <= p2_pin_o;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (p2_oe_i[i]) begin
        p2_pin_o[i] = p2_out_i[i];
      end else if (p2_ext_en_i[i]) begin
        p2_pin_o[i] = p2_ext_i[i];
      end else if (p2_pu_i[i]) begin
        p2_pin_o[i] = 1'b1;
      end else begin
        p2_pin_o[i] = ~last_q[i];
      end
    end
    for (int j = 0; j < 7; j++) begin
      p0_pin_o[j] = p0_oe_i[j] ? p0_out_i[j] : p0_ext_i[j];
    end
  end
endmodule

// ===== sim/mpc_port_io_tb_top.sv
// Self-checking bench for the port and comparator I/O block.
// Assumes the AXI4-Lite slave answers within 50 cycles.
`timescale 1ns/1ns
module mpc_port_io_tb_top;
  // ****
  // Signals
  // ****
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, wdt_rst_i = 1'b0;
  logic stop_mode_i = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, port3_out_a_o, port3_out_b_o, port3_out_c_o;
  logic port3_slew_o, comp_en_o, timer1_in_o;
  logic ext_int_zero_o, ext_int_one_o, ext_int_two_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, hs_sel_i = 2'h0;
  logic [31:0] s_axi_rdata, rv;
  logic [6:0] port0_in_i, port0_out_o, port0_oe_o, p0_ext = 7'h2A;
  logic [7:0] port2_lines_in_i, port2_lines_out_o, port2_lines_oe_o;
  logic [7:0] port2_pullup_o, adc_chan_en_o, stop_src_i = 8'h00;
  logic [7:0] p2_ext = 8'h06, p2_ext_en = 8'h0F;
  logic port3_in_a_i = 1'b1, port3_in_b_i = 1'b1, port3_in_ref_i = 1'b1;
  logic comparator_a_i = 1'b0, comparator_b_i = 1'b0;
  logic port0_hs_i = 1'b0, timer1_out_i = 1'b0, port2_hs_i = 1'b0;
  int err_total = 0, checked = 0;
  logic [4:0] rows [8] = '{5'b00100, 5'b00011, 5'b01101, 5'b01010,
                           5'b10110, 5'b10001, 5'b11111, 5'b11011};

  always #25 ref_clk_i = ~ref_clk_i;

  mpc_port_io dut_u (.ref_clk_i, .rst_n_i, .wdt_rst_i, .stop_mode_i,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .port0_in_i, .port0_out_o, .port0_oe_o,
    .port2_lines_in_i, .port2_lines_out_o, .port2_lines_oe_o,
    .port2_pullup_o, .adc_chan_en_o, .port3_in_a_i, .port3_in_b_i,
    .port3_in_ref_i, .comparator_a_i, .comparator_b_i, .stop_src_i,
    .port0_hs_i, .timer1_out_i, .port2_hs_i, .hs_sel_i, .port3_out_a_o,
    .port3_out_b_o, .port3_out_c_o, .port3_slew_o, .comp_en_o,
    .timer1_in_o, .ext_int_zero_o, .ext_int_one_o, .ext_int_two_o);

  mpc_pin_model pins_u (.ref_clk_i(ref_clk_i), .p2_out_i(port2_lines_out_o),
    .p2_oe_i(port2_lines_oe_o), .p2_pu_i(port2_pullup_o), .p2_ext_i(p2_ext),
    .p2_ext_en_i(p2_ext_en), .p0_out_i(port0_out_o), .p0_oe_i(port0_oe_o),
    .p0_ext_i(p0_ext), .p2_pin_o(port2_lines_in_i), .p0_pin_o(port0_in_i));

  // ****
  // Tasks
  // ****
  task automatic results();
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang();
    err_total++;
    results();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge ref_clk_i);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang();
  endtask

  // Lets a pin edge reach the event flags before the next access
  task automatic settle();
    repeat (4) @(posedge ref_clk_i);
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    logic [1:0] rs;
    repeat (20) @(posedge ref_clk_i);
    chk({port0_oe_o, port2_lines_oe_o, port2_pullup_o}, 32'h0);
    rst_n_i <= 1'b1;
    settle();
    chk({port0_oe_o, port2_lines_oe_o, adc_chan_en_o}, 32'hFF);
    rd(mpc_pkg::PORT_CONFIG_OFF, rv, rs);
    chk(rv, 32'h0);
    // Edge select table, rising then falling on inputs a and b
    for (int i = 0; i < 8; i++) begin
      wr(mpc_pkg::IRQ_EDGE_OFF, {24'h0, rows[i][4:3], 6'h0});
      port3_in_a_i <= ~rows[i][2];
      port3_in_b_i <= ~rows[i][2];
      settle();
      wr(mpc_pkg::EVENT_OFF, 32'h7);
      port3_in_a_i <= rows[i][2];
      port3_in_b_i <= rows[i][2];
      settle();
      rd(mpc_pkg::EVENT_OFF, rv, rs);
      chk(rv, {30'h0, rows[i][0], rows[i][1]});
    end
    // Ref input falls in digital mode
    wr(mpc_pkg::EVENT_OFF, 32'h7);
    port3_in_ref_i <= 1'b0;
    settle();
    rd(mpc_pkg::EVENT_OFF, rv, rs);
    chk(rv, 32'h4);
    // Groups directed separately
    wr(mpc_pkg::PORT0_DATA_OFF, 32'h7F);
    wr(mpc_pkg::PORT0_MODE_OFF, 32'h1);
    settle();
    chk({25'h0, port0_oe_o}, 32'h70);
    wr(mpc_pkg::PORT0_MODE_OFF, 32'h2);
    settle();
    chk({25'h0, port0_oe_o}, 32'h0F);
    rd(mpc_pkg::PORT0_DATA_OFF, rv, rs);
    chk(rv, 32'h2F);
    // Low nibble input with pull-ups, high nibble output
    wr(mpc_pkg::PORT2_PULLUP_OFF, 32'hFF);
    wr(mpc_pkg::PORT2_DATA_OFF, 32'hA5);
    wr(mpc_pkg::PORT2_MODE_OFF, 32'h0F);
    settle();
    chk({port2_pullup_o, port2_lines_oe_o}, 32'h0FF0);
    chk({17'h0, port0_out_o, port2_lines_out_o}, 32'h7FA5);
    rd(mpc_pkg::PORT2_DATA_OFF, rv, rs);
    chk(rv & 32'hF, 32'h6);
    p2_ext_en <= 8'h00;
    settle();
    rd(mpc_pkg::PORT2_DATA_OFF, rv, rs);
    chk(rv & 32'hF, 32'hF);
    // Output a routing, then watchdog inside and outside stop mode
    wr(mpc_pkg::PORT3_DATA_OFF, 32'h08);
    wr(mpc_pkg::PORT_CONFIG_OFF, 32'h1);
    settle();
    chk({31'h0, port3_out_a_o}, 32'h0);
    wr(mpc_pkg::PORT_CONFIG_OFF, 32'h0);
    settle();
    chk({31'h0, port3_out_a_o}, 32'h1);
    wr(mpc_pkg::PORT3_DATA_OFF, 32'h00);
    wr(mpc_pkg::PORT_CONFIG_OFF, 32'h1);
    comparator_a_i <= 1'b1;
    stop_mode_i <= 1'b1;
    wdt_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    wdt_rst_i <= 1'b0;
    settle();
    chk({31'h0, port3_out_a_o}, 32'h1);
    stop_mode_i <= 1'b0;
    wdt_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    wdt_rst_i <= 1'b0;
    settle();
    chk({31'h0, port3_out_a_o}, 32'h0);
    // Analog mode; switch is followed by a wait and a flag clear
    wr(mpc_pkg::PORT3_MODE_OFF, 32'h3);
    settle();
    wr(mpc_pkg::EVENT_OFF, 32'h7);
    chk({30'h0, comp_en_o, port3_slew_o}, 32'h3);
    stop_src_i <= 8'h01;
    comparator_b_i <= 1'b1;
    settle();
    stop_src_i <= 8'h00;
    settle();
    rd(mpc_pkg::EVENT_OFF, rv, rs);
    chk(rv, 32'h6);
    rd(mpc_pkg::PORT3_DATA_OFF, rv, rs);
    chk(rv, 32'h3);
    // Handshake and timer sources onto the fixed outputs
    hs_sel_i <= 2'h3;
    port0_hs_i <= 1'b1;
    port2_hs_i <= 1'b1;
    settle();
    chk({29'h0, port3_out_a_o, port3_out_b_o, port3_out_c_o}, 32'h3);
    hs_sel_i <= 2'h0;
    timer1_out_i <= 1'b1;
    settle();
    chk({30'h0, port3_out_b_o, port3_out_c_o}, 32'h1);
    chk({31'h0, timer1_in_o}, 32'h1);
    // Unmapped address
    rd(8'h3C, rv, rs);
    chk({rs, rv[29:0]}, {mpc_pkg::RESP_SLVERR, 30'h0});
    results();
  end
endmodule
